/* fan_edge_detect.sv */
// Two-stage synchroniser and edge detector for the fan speed input
`timescale 1ns/1ps
module fan_edge_detect (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic fan_raw,
  output logic      rise_pulse,
  output logic      edge_pulse
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  // Second stage alone feeds the detector, so one edge gives one pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= fan_raw;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise_pulse = sync2_r & ~prev_r;
  assign edge_pulse = sync2_r ^ prev_r;
endmodule : fan_edge_detect

/* fan_model.sv */
// Fan tachometer model: square wave while spinning
`timescale 1ns/1ps
module fan_model (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [15:0] half,
  output logic             fan_out
);
  logic [15:0] cnt_r;

  // Stalled fan parks low so no stray rising edge appears after a stop
  always @(posedge clk) begin
    if (!run) begin
      cnt_r <= 16'h0;
      fan_out <= 1'b0;
    end else if (cnt_r == half - 16'h1) begin
      cnt_r <= 16'h0;
      fan_out <= ~fan_out;
    end else begin
      cnt_r <= cnt_r + 16'h1;
    end
  end
endmodule : fan_model

/* fan_tach_assertions.sv */
// Port-level checks of the fan speed monitor
`timescale 1ns/1ps
module fan_tach_assertions (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fan_speed_input,
  input wire logic        sleep_req,
  input wire logic        fan_irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  wire logic acc    = psel && penable;
  wire logic mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};
  wire logic rd     = acc && !pwrite;

  sequence mask_write;
    acc && pwrite && paddr == 8'h00 && !pwdata[2] && pwdata[15:14] == 2'h0;
  endsequence
  sequence quiet_sleep;
    (sleep_req && !psel)[*4];
  endsequence

  a_pready_high: assert property (acc |-> pready) else $error("pready low");
  a_idle_rdata_zero: assert property (!psel |-> prdata == 32'h0)
    else $error("idle read data not zero");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr) else $error("no slverr");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("false slverr");
  a_unmapped_zero: assert property (rd && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_reserved: assert property (rd && paddr == 8'h00 |-> !prdata[13] && prdata[10:3] == 8'h0)
    else $error("ctrl reserved bits set");
  a_stat_reserved: assert property (rd && paddr == 8'h04 |-> prdata[31:3] == 29'h0)
    else $error("status reserved bits set");
  a_reset_irq_low: assert property ($rose(nrst) |-> !fan_irq) else $error("irq after reset");
  a_masked_irq: assert property (mask_write |=> !fan_irq) else $error("masked irq high");
  a_sleep_quiet: assert property (quiet_sleep |-> $stable(fan_irq))
    else $error("irq moved asleep");
endmodule : fan_tach_assertions

bind fan_tach_speed_monitor fan_tach_assertions u_chk (.*);

/* fan_tach_cfg.svh */
// Offsets, field positions, reset values and timing counts of the fan speed monitor
`ifndef FAN_TACH_CFG_SVH
`define FAN_TACH_CFG_SVH

`define FT_OFF_CTRL        8'h00
`define FT_OFF_STAT        8'h04
`define FT_OFF_HIGH        8'h08
`define FT_OFF_LOW         8'h0C

`define FT_CTRL_ENABLE     0
`define FT_CTRL_MODE       1
`define FT_CTRL_LIMIT_IE   2
`define FT_CTRL_EDGES_LO   11
`define FT_CTRL_EDGES_HI   12
`define FT_CTRL_READY_IE   14
`define FT_CTRL_TOGGLE_IE  15
`define FT_CTRL_READING_LO 16
`define FT_CTRL_READING_HI 31

`define FT_STAT_LIMIT      0
`define FT_STAT_TOGGLE     1
`define FT_STAT_READY      2

`define FT_RST_HIGH        16'hFFFF
`define FT_RST_LOW         16'h0000
`define FT_RST_LIMIT_IE    1'b1
`define FT_RST_EDGES       2'h0

`define FT_EDGES_SEL0      4'h2
`define FT_EDGES_SEL1      4'h3
`define FT_EDGES_SEL2      4'h5
`define FT_EDGES_SEL3      4'h9

`define FT_COUNT_MAX       16'hFFFF

`define FT_CLK_HZ          250000000
`define FT_SLOW_HZ         100000
`define FT_SLOW_DIV        (`FT_CLK_HZ / `FT_SLOW_HZ)

`endif

/* fan_tach_pkg.sv */
// Types shared by the fan speed monitor
package fan_tach_pkg;
  typedef enum logic {
    mode_free_run,
    mode_clock_count
  } read_mode_t;

  typedef enum logic [1:0] {
    meas_wait,
    meas_run
  } meas_state_t;
endpackage : fan_tach_pkg

/* fan_tach_speed_monitor.sv */
// Fan speed monitor: edge counter, interval timer, limits, status and APB registers
//
// Contract
// R1: Two counting modes chosen by mode select bit
// R2: Mode 0 counts rising fan input edges
// R3: Mode 0 counter wraps FFFFh to 0000h freely
// R4: Firmware differences readings, samples before wrap
// R5: Firmware keeps interrupts off in Mode 0
// R6: Mode 1 counts 100 kHz cycles over edges
// R7: Firmware selects five edges for typical fans
// R8: Mode 1 latches reading, sets count-ready flag
// R9: Count-ready with its enable raises interrupt
// R10: Flag set when reading beyond high/low limit
// R11: Out-of-limit flag generates interrupt event
// R12: Interrupt output ORs held status events
// R13: Reset returns all state to defaults
// R14: Disable bit or sleep stops monitoring
// R15: Four registers at 00h, 04h, 08h, 0Ch
// R16: Handles 100 to 30,000 rpm without loss
// R17: Edge select 00=2, 01=3, 10=5, 11=9
// R18: Latch at FFFFh, clear counter after copy
// R19: Fan input synchronised before edge detection
`include "fan_tach_cfg.svh"
`timescale 1ns/1ps
module fan_tach_speed_monitor
  import fan_tach_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fan_speed_input,
  input  wire logic        sleep_req,
  output logic             fan_irq
);

  localparam logic [11:0] SLOW_LAST = 12'(`FT_SLOW_DIV - 1);

  // Register state
  logic        enable_r;
  read_mode_t  mode_r;
  logic        limit_ie_r;
  logic [1:0]  edges_sel_r;
  logic        ready_ie_r;
  logic        toggle_ie_r;
  logic [15:0] pulse_count_reading_r;
  logic [15:0] high_limit_r;
  logic [15:0] low_limit_r;
  logic        out_of_limit_flag_r;
  logic        toggle_flag_r;
  logic        ready_flag_r;

  // Measurement state
  meas_state_t state_r;
  meas_state_t state_nxt;
  logic [15:0] interval_cnt_r;
  logic [15:0] interval_cnt_nxt;
  logic [3:0]  edges_seen_r;
  logic [3:0]  edges_seen_nxt;
  logic [11:0] div_cnt_r;
  logic [15:0] reading_nxt;
  logic        reading_load;

  // Bus decode
  logic        access;
  logic        wr_en;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_high;
  logic        hit_low;
  logic        mapped;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_high;
  logic        wr_low;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic [31:0] high_rd;
  logic [31:0] low_rd;
  logic        rd_setup;
  logic [31:0] rd_mux;
  logic [31:0] prdata_r;

  // Event wires
  logic        rise_pulse;
  logic        edge_pulse;
  logic        active;
  logic        slow_tick;
  logic [3:0]  edges_target;
  logic        interval_done;
  logic        count_full;
  logic        set_limit;
  logic        set_toggle;
  logic        set_ready;
  logic        clr_limit;
  logic        clr_toggle;
  logic        clr_ready;
  logic        beyond_limit;

  fan_edge_detect u_edge (
    .clk        (clk),
    .nrst       (nrst),
    .fan_raw    (fan_speed_input),
    .rise_pulse (rise_pulse),
    .edge_pulse (edge_pulse)
  ); // R19

  // APB slave, zero wait states
  assign access   = psel & penable;
  assign wr_en    = access & pwrite;
  assign hit_ctrl = (paddr == `FT_OFF_CTRL); // R15
  assign hit_stat = (paddr == `FT_OFF_STAT); // R15
  assign hit_high = (paddr == `FT_OFF_HIGH); // R15
  assign hit_low  = (paddr == `FT_OFF_LOW); // R15
  assign mapped   = hit_ctrl | hit_stat | hit_high | hit_low;
  assign wr_ctrl  = wr_en & hit_ctrl;
  assign wr_stat  = wr_en & hit_stat;
  assign wr_high  = wr_en & hit_high;
  assign wr_low   = wr_en & hit_low;
  assign pready   = 1'b1;
  assign pslverr  = access & ~mapped;

  assign ctrl_rd = {pulse_count_reading_r, toggle_ie_r, ready_ie_r, 1'b0, edges_sel_r,
                    8'h00, limit_ie_r, mode_r, enable_r};
  assign stat_rd = {29'h0000_0000, ready_flag_r, toggle_flag_r, out_of_limit_flag_r};
  assign high_rd = {16'h0000, high_limit_r};
  assign low_rd  = {16'h0000, low_limit_r};

  // Read data leaves a flop, captured in the setup cycle of a read
  assign rd_setup = psel & ~penable & ~pwrite;
  assign rd_mux   = hit_ctrl ? ctrl_rd :
                    hit_stat ? stat_rd :
                    hit_high ? high_rd :
                    hit_low  ? low_rd  : 32'h0000_0000; // R15

  // Zero outside a read, so an idle bus shows no stale register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= 32'h0000_0000; // R13
    end else if (rd_setup) begin
      prdata_r <= rd_mux;
    end else begin
      prdata_r <= 32'h0000_0000;
    end
  end

  assign prdata = prdata_r;

  // Monitoring halts while disabled or asleep
  assign active = enable_r & ~sleep_req; // R14

  // 100 kHz measurement rate as a one-cycle enable
  assign slow_tick = active & (div_cnt_r == SLOW_LAST);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_r <= 12'h000;
    end else if (!active || slow_tick) begin
      div_cnt_r <= 12'h000;
    end else begin
      div_cnt_r <= div_cnt_r + 12'h001;
    end
  end

  always_comb begin
    unique case (edges_sel_r)
      2'b00: edges_target = `FT_EDGES_SEL0; // R17
      2'b01: edges_target = `FT_EDGES_SEL1; // R17
      2'b10: edges_target = `FT_EDGES_SEL2; // R17
      2'b11: edges_target = `FT_EDGES_SEL3; // R17
    endcase
  end

  // Closing edge of an interval also opens the next, so no edge is lost
  assign interval_done = (state_r == meas_run) & edge_pulse &
                         ((edges_seen_r + 4'h1) == edges_target); // R8
  // 16 bits at 100 kHz span the slowest fan's interval
  assign count_full    = (state_r == meas_run) & slow_tick & ~interval_done &
                         (interval_cnt_r == (`FT_COUNT_MAX - 16'h0001)); // R16 R18

  always_comb begin
    state_nxt        = state_r;
    interval_cnt_nxt = interval_cnt_r;
    edges_seen_nxt   = edges_seen_r;
    reading_nxt      = pulse_count_reading_r;
    reading_load     = 1'b0;
    if (!active) begin
      state_nxt        = meas_wait;
      interval_cnt_nxt = 16'h0000;
      edges_seen_nxt   = 4'h0;
    end else if (mode_r == mode_free_run) begin // R1
      state_nxt        = meas_wait;
      interval_cnt_nxt = 16'h0000;
      edges_seen_nxt   = 4'h0;
      // 16-bit add wraps FFFFh to 0000h by itself
      if (rise_pulse) begin
        reading_nxt  = pulse_count_reading_r + 16'h0001; // R2 R3
        reading_load = 1'b1;
      end
    end else begin
      unique case (state_r)
        meas_wait: begin
          if (edge_pulse) begin
            state_nxt        = meas_run;
            interval_cnt_nxt = 16'h0000;
            edges_seen_nxt   = 4'h1;
          end
        end
        meas_run: begin
          if (interval_done) begin
            reading_nxt      = interval_cnt_r; // R6 R8
            reading_load     = 1'b1;
            interval_cnt_nxt = 16'h0000; // R18
            edges_seen_nxt   = 4'h1;
          end else if (count_full) begin
            reading_nxt      = `FT_COUNT_MAX; // R18
            reading_load     = 1'b1;
            interval_cnt_nxt = 16'h0000; // R18
            edges_seen_nxt   = 4'h0;
            state_nxt        = meas_wait;
          end else begin
            if (slow_tick) begin
              interval_cnt_nxt = interval_cnt_r + 16'h0001; // R6
            end
            if (edge_pulse) begin
              edges_seen_nxt = edges_seen_r + 4'h1;
            end
          end
        end
        default: begin
          state_nxt = meas_wait;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r        <= meas_wait; // R13
      interval_cnt_r <= 16'h0000;
      edges_seen_r   <= 4'h0;
    end else begin
      state_r        <= state_nxt;
      interval_cnt_r <= interval_cnt_nxt;
      edges_seen_r   <= edges_seen_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_count_reading_r <= 16'h0000; // R13
    end else if (reading_load) begin
      pulse_count_reading_r <= reading_nxt;
    end
  end

  // Limit check on every new reading
  assign beyond_limit = (reading_nxt > high_limit_r) | (reading_nxt < low_limit_r);
  assign set_limit    = reading_load & beyond_limit; // R10
  assign set_toggle   = active & edge_pulse;
  assign set_ready    = reading_load & (mode_r == mode_clock_count) & ~count_full; // R8

  assign clr_limit  = wr_stat & pwdata[`FT_STAT_LIMIT];
  assign clr_toggle = wr_stat & pwdata[`FT_STAT_TOGGLE];
  assign clr_ready  = wr_stat & pwdata[`FT_STAT_READY];

  // Set beats a same-cycle write-one-to-clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_of_limit_flag_r <= 1'b0; // R13
    end else begin
      out_of_limit_flag_r <= set_limit | (out_of_limit_flag_r & ~clr_limit); // R10
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      toggle_flag_r <= 1'b0; // R13
    end else begin
      toggle_flag_r <= set_toggle | (toggle_flag_r & ~clr_toggle);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ready_flag_r <= 1'b0; // R13
    end else begin
      ready_flag_r <= set_ready | (ready_flag_r & ~clr_ready); // R8
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enable_r <= 1'b0; // R13
      mode_r   <= mode_free_run;
    end else if (wr_ctrl) begin
      enable_r <= pwdata[`FT_CTRL_ENABLE]; // R14
      mode_r   <= read_mode_t'(pwdata[`FT_CTRL_MODE]); // R1
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      limit_ie_r  <= `FT_RST_LIMIT_IE; // R13
      edges_sel_r <= `FT_RST_EDGES;
    end else if (wr_ctrl) begin
      limit_ie_r  <= pwdata[`FT_CTRL_LIMIT_IE];
      edges_sel_r <= pwdata[`FT_CTRL_EDGES_HI:`FT_CTRL_EDGES_LO]; // R17
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ready_ie_r  <= 1'b0; // R13
      toggle_ie_r <= 1'b0;
    end else if (wr_ctrl) begin
      ready_ie_r  <= pwdata[`FT_CTRL_READY_IE]; // R9
      toggle_ie_r <= pwdata[`FT_CTRL_TOGGLE_IE];
    end
  end

  // New limits apply from the next reading on
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      high_limit_r <= `FT_RST_HIGH; // R13
    end else if (wr_high) begin
      high_limit_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_limit_r <= `FT_RST_LOW; // R13
    end else if (wr_low) begin
      low_limit_r <= pwdata[15:0];
    end
  end

  // Level interrupt from held status bits through their enables
  assign fan_irq = (out_of_limit_flag_r & limit_ie_r) | // R11 R12
                   (ready_flag_r & ready_ie_r) | // R9 R12
                   (toggle_flag_r & toggle_ie_r); // R12

endmodule : fan_tach_speed_monitor

/* testbench.sv */
// Register-level regression of the fan speed monitor
`timescale 1ns/1ps
module testbench;
  logic        clk, nrst, psel, penable, pwrite, sleep_req, run, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, q;
  logic [15:0] half, r0;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, fan_irq, fan;
  int err_count = 0;
  int num_checks = 0;
  localparam logic [15:0] RST_V [4] = '{16'h0004, 16'h0000, 16'hFFFF, 16'h0000};
  localparam logic [4:0]  EDGES [4] = '{5'h02, 5'h03, 5'h05, 5'h09};

  fan_tach_speed_monitor u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fan_speed_input(fan), .sleep_req(sleep_req), .fan_irq(fan_irq));
  fan_model u_fan (.clk(clk), .run(run), .half(half), .fan_out(fan));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer

  task automatic wait_ready;
    do xfer(1'b0, 8'h04, 32'h0); while (q[2] !== 1'b1);
  endtask : wait_ready

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; sleep_req = 1'b0; run = 1'b0; half = 16'h0004;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", q, {16'h0, RST_V[i]});
    end
    xfer(1'b1, 8'h10, 32'hFFFFFFFF);
    chk("unmapped error", 32'(err), 32'h1);
    xfer(1'b0, 8'h00, 32'h0);
    chk("ctrl untouched", q, 32'h4);
    // Free-running count, awake then asleep; interrupts stay off here
    for (int s = 0; s < 2; s++) begin
      sleep_req <= s[0];
      xfer(1'b1, 8'h04, 32'h7);
      xfer(1'b1, 8'h00, 32'h1);
      xfer(1'b0, 8'h00, 32'h0);
      r0 = q[31:16];
      run <= 1'b1;
      repeat (82) @(posedge clk);
      run <= 1'b0;
      repeat (6) @(posedge clk);
      xfer(1'b0, 8'h00, 32'h0);
      chk("pulse delta", 32'(16'(q[31:16] - r0)), (s == 0) ? 32'hA : 32'h0);
      xfer(1'b0, 8'h04, 32'h0);
      chk("toggle flag", 32'(q[1]), (s == 0) ? 32'h1 : 32'h0);
    end
    sleep_req <= 1'b0;
    half <= 16'h09C4;
    run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'h00, 32'h0);
      xfer(1'b1, 8'h04, 32'h7);
      xfer(1'b1, 8'h00, 32'h4007 | (32'(i) << 11));
      wait_ready();
      xfer(1'b0, 8'h00, 32'h0);
      chk("interval ticks", 32'(q[31:16]), 32'(EDGES[i] - 5'h01));
      chk("ready irq", 32'(fan_irq), 32'h1);
    end
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b1, 8'h04, 32'h7);
    xfer(1'b1, 8'h0C, 32'h5);
    xfer(1'b1, 8'h00, 32'h0007);
    wait_ready();
    chk("limit flag", 32'(q[0]), 32'h1);
    chk("limit irq", 32'(fan_irq), 32'h1);
    xfer(1'b1, 8'h00, 32'h0);
    chk("masked irq", 32'(fan_irq), 32'h0);
    xfer(1'b1, 8'h00, 32'h8000);
    chk("toggle irq", 32'(fan_irq), 32'h1);
    xfer(1'b1, 8'h04, 32'h7);
    chk("irq after clear", 32'(fan_irq), 32'h0);
    xfer(1'b0, 8'h04, 32'h0);
    chk("status cleared", q, 32'h0);
    run <= 1'b0;
    end_of_test();
  end
endmodule : testbench
